// File: dmcp_pkg.sv
/*
 * dmcp_pkg: constants, field layouts, encodings and state types shared by the
 * dual-mode control port device end, its host end and the testbench.
 * assumes: one system clock of 100 MHz on both ends; no imports anywhere.
 */
// Summary of operation
// - port runs independent of any audio timing
// - host keeps lines static when idle
// - host keeps master clock running during I2C
// - pointer holds when auto-increment is clear
// - pointer advances per data byte when set
// - I2C address 001000, select pin, then R/W
// - I2C by default; select-pin fall locks SPI
// - I2C write: address, pointer, then data byte
// - I2C block write streams bytes, ends STOP
// - no increment: repeated START for other register
// - I2C read shifts out pointed register
// - read uses last written or reset pointer
// - read continues while host acknowledges bytes
// - no increment: STOP, reload pointer, read again
// - SPI inputs only, sampled on clock rise
// - SPI write: 00100000, pointer, then data
// - SPI streams with increment, else reframe
// - pointer byte: flag bit7, index bits3-0
// - I2C reads and writes, SPI writes only
package dmcp_pkg;
	localparam int        IDX_W         = 4;
	localparam logic [5:0] DEV_ADDR_HI  = 6'h08;
	localparam logic [7:0] SPI_ADDR     = 8'h20;
	localparam int        PTR_INC_BIT   = 7;
	localparam logic [3:0] PTR_IDX_RST  = 4'h0;
	localparam logic      PTR_INC_RST   = 1'h0;
	localparam logic [3:0] BITS_ACK     = 4'h8;
	localparam logic [3:0] BITS_END     = 4'h9;
	localparam logic [3:0] BITS_SPI     = 4'h7;
	localparam logic [1:0] ARM_DONE     = 2'h3;
	localparam int        CLK_PERIOD_NS = 10;
	localparam int        SCL_PERIOD_NS = 10000;
	localparam int        QTR_CYCLES    = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [2:0] HR_CMD       = 3'h0;
	localparam logic [2:0] HR_PTR       = 3'h1;
	localparam logic [2:0] HR_TX        = 3'h2;
	localparam logic [2:0] HR_CFG       = 3'h3;
	localparam logic [2:0] HR_RX        = 3'h4;
	localparam logic [2:0] HR_STAT      = 3'h5;
	localparam logic [1:0] OP_WRITE     = 2'h0;
	localparam logic [1:0] OP_SETPTR    = 2'h1;
	localparam logic [1:0] OP_READ      = 2'h2;
	localparam logic [1:0] OP_SPI       = 2'h3;
	localparam logic [1:0] Q_SET        = 2'h0;
	localparam logic [1:0] Q_RISE       = 2'h1;
	localparam logic [1:0] Q_SAMPLE     = 2'h2;
	localparam logic [1:0] Q_FALL       = 2'h3;

	typedef enum logic [2:0]
	{
		DS_IDLE  = 3'h0,
		DS_ADDR  = 3'h1,
		DS_PTR   = 3'h3,
		DS_WDATA = 3'h2,
		DS_RDATA = 3'h6,
		DS_SKIP  = 3'h4
	} dmcp_dev_state_t;

	typedef enum logic [1:0]
	{
		HS_IDLE  = 2'h0,
		HS_START = 2'h1,
		HS_BIT   = 2'h3,
		HS_STOP  = 2'h2
	} dmcp_host_state_t;
endpackage : dmcp_pkg

// File: dmcp_if.sv
/*
 * dmcp_if: the shared pins between host and device.
 * assumes: the data pin is open drain with a pull-up; the host may also drive
 * it high in SPI mode, which resolves to the same level.
 */
`timescale 1ns/1ps
interface dmcp_if;
	logic serial_control_clock;
	logic address_select_pin;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_oe_n;
	logic sda;

	// wired-and with pull-up
	assign sda = ~((~host_sda_oe_n & ~host_sda_o) | ~dev_sda_oe_n);

	modport device
	(
		input  serial_control_clock,
		input  address_select_pin,
		input  sda,
		output dev_sda_oe_n
	);
	modport host
	(
		output serial_control_clock,
		output address_select_pin,
		output host_sda_o,
		output host_sda_oe_n,
		input  sda
	);
endinterface : dmcp_if

// File: dmcp_sync.sv
/*
 * dmcp_sync: two-flop synchroniser, one stage pair per bit.
 * assumes: inputs are asynchronous pins; reset value is a constant parameter.
 */
`timescale 1ns/1ps
module dmcp_sync
#(
	parameter int              WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
)
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					meta_reg[i] <= RESET_VAL[i];
					q[i]        <= RESET_VAL[i];
				end
				else
				begin
					meta_reg[i] <= d[i];
					q[i]        <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule : dmcp_sync

// File: dmcp_device.sv
/*
 * dmcp_device: device end of the dual-mode control port. Decodes I2C or SPI
 * traffic, keeps the register pointer, issues register writes and fetches
 * register reads through the user-side port.
 * assumes: register storage lives outside; reg_rd_data follows reg_rd_index
 * combinationally on the same clock; clk is far faster than the serial clock.
 */
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
module dmcp_device
(
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	dmcp_if.device                         link,
	output logic                           reg_wr,
	output logic [dmcp_pkg::IDX_W-1:0]     reg_wr_index,
	output logic [7:0]                     reg_wr_data,
	output logic [dmcp_pkg::IDX_W-1:0]     reg_rd_index,
	input  wire logic [7:0]                reg_rd_data,
	output logic                           spi_mode,
	output logic                           pointer_auto_increment
);
	logic [2:0]                  pins_s;
	logic                        scl_s;
	logic                        sda_s;
	logic                        adcs_s;
	logic                        scl_d_reg;
	logic                        sda_d_reg;
	logic                        adcs_d_reg;
	logic [1:0]                  arm_reg;
	logic [1:0]                  arm_next;
	dmcp_pkg::dmcp_dev_state_t   state_reg;
	dmcp_pkg::dmcp_dev_state_t   state_next;
	logic [3:0]                  cnt_reg;
	logic [3:0]                  cnt_next;
	logic [7:0]                  shift_reg;
	logic [7:0]                  shift_next;
	logic                        rw_reg;
	logic                        rw_next;
	logic                        nack_reg;
	logic                        nack_next;
	logic                        oe_n_reg;
	logic                        oe_n_next;
	logic                        spi_reg;
	logic                        spi_next;
	logic                        inc_reg;
	logic                        inc_next;
	logic [dmcp_pkg::IDX_W-1:0]  idx_reg;
	logic [dmcp_pkg::IDX_W-1:0]  idx_next;
	logic                        wr_reg;
	logic                        wr_next;
	logic [dmcp_pkg::IDX_W-1:0]  wr_idx_reg;
	logic [dmcp_pkg::IDX_W-1:0]  wr_idx_next;
	logic [7:0]                  wr_data_reg;
	logic [7:0]                  wr_data_next;

	// pins are asynchronous to clk; no audio timing is involved
	dmcp_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync
	(
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({link.serial_control_clock, link.sda, link.address_select_pin}),
		.q     (pins_s)
	);

	assign scl_s  = pins_s[2];
	assign sda_s  = pins_s[1];
	assign adcs_s = pins_s[0];

	// select-pin edge detectors stay blind until the sync chain holds real pin levels
	wire armed     = (arm_reg == dmcp_pkg::ARM_DONE);
	wire scl_rise  = ~scl_d_reg & scl_s;
	wire scl_fall  = scl_d_reg & ~scl_s;
	wire cs_fall   = armed & adcs_d_reg & ~adcs_s;
	wire cs_rise   = armed & ~adcs_d_reg & adcs_s;
	wire i2c_start = ~spi_reg & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire i2c_stop  = ~spi_reg & scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
	wire addr_match = (shift_reg[7:1] == {dmcp_pkg::DEV_ADDR_HI, adcs_s});
	wire [dmcp_pkg::IDX_W-1:0] idx_step = inc_reg ? idx_reg + 4'h1 : idx_reg;
	wire rx_state = (state_reg == dmcp_pkg::DS_ADDR) | (state_reg == dmcp_pkg::DS_PTR)
		| (state_reg == dmcp_pkg::DS_WDATA);
	wire spi_shift = ~adcs_s & scl_rise & rx_state;
	wire spi_byte  = (cnt_reg == dmcp_pkg::BITS_SPI);

	always_comb
	begin
		arm_next     = armed ? arm_reg : arm_reg + 2'h1;
		state_next   = state_reg;
		cnt_next     = cnt_reg;
		shift_next   = shift_reg;
		rw_next      = rw_reg;
		nack_next    = nack_reg;
		oe_n_next    = oe_n_reg;
		spi_next     = spi_reg;
		inc_next     = inc_reg;
		idx_next     = idx_reg;
		wr_next      = 1'b0;
		wr_idx_next  = wr_idx_reg;
		wr_data_next = wr_data_reg;
		if (cs_fall)
		begin
			// one-way switch; only reset returns to I2C
			spi_next   = 1'b1;
			state_next = dmcp_pkg::DS_ADDR;
			cnt_next   = 4'h0;
			oe_n_next  = 1'b1;
		end
		else if (spi_reg)
		begin
			if (cs_rise)
			begin
				state_next = dmcp_pkg::DS_IDLE;
				cnt_next   = 4'h0;
			end
			else if (spi_shift)
			begin
				shift_next = rx_byte;
				cnt_next   = spi_byte ? 4'h0 : cnt_reg + 4'h1;
				if (spi_byte)
				begin
					case (state_reg)
						dmcp_pkg::DS_ADDR:
							state_next = (rx_byte == dmcp_pkg::SPI_ADDR) ? dmcp_pkg::DS_PTR
								: dmcp_pkg::DS_SKIP;
						dmcp_pkg::DS_PTR:
						begin
							inc_next   = rx_byte[dmcp_pkg::PTR_INC_BIT];
							idx_next   = rx_byte[dmcp_pkg::IDX_W-1:0];
							state_next = dmcp_pkg::DS_WDATA;
						end
						default:
						begin
							// write only: SPI never fetches read data
							wr_next      = 1'b1;
							wr_idx_next  = idx_reg;
							wr_data_next = rx_byte;
							idx_next     = idx_step;
						end
					endcase
				end
			end
		end
		else if (i2c_start)
		begin
			state_next = dmcp_pkg::DS_ADDR;
			cnt_next   = 4'h0;
			oe_n_next  = 1'b1;
		end
		else if (i2c_stop)
		begin
			state_next = dmcp_pkg::DS_IDLE;
			cnt_next   = 4'h0;
			oe_n_next  = 1'b1;
		end
		else if (scl_rise & (rx_state | (state_reg == dmcp_pkg::DS_RDATA)))
		begin
			if ((cnt_reg < dmcp_pkg::BITS_ACK) & (state_reg != dmcp_pkg::DS_RDATA))
				shift_next = rx_byte;
			if ((cnt_reg == dmcp_pkg::BITS_ACK) & (state_reg == dmcp_pkg::DS_RDATA))
				nack_next = sda_s;
			cnt_next = cnt_reg + 4'h1;
		end
		else if (scl_fall & (cnt_reg == dmcp_pkg::BITS_ACK))
		begin
			case (state_reg)
				dmcp_pkg::DS_ADDR:
				begin
					oe_n_next  = ~addr_match;
					rw_next    = shift_reg[0];
					state_next = addr_match ? dmcp_pkg::DS_ADDR : dmcp_pkg::DS_SKIP;
				end
				dmcp_pkg::DS_PTR:
				begin
					oe_n_next = 1'b0;
					inc_next  = shift_reg[dmcp_pkg::PTR_INC_BIT];
					idx_next  = shift_reg[dmcp_pkg::IDX_W-1:0];
				end
				dmcp_pkg::DS_WDATA:
				begin
					oe_n_next    = 1'b0;
					wr_next      = 1'b1;
					wr_idx_next  = idx_reg;
					wr_data_next = shift_reg;
					idx_next     = idx_step;
				end
				dmcp_pkg::DS_RDATA:
				begin
					oe_n_next = 1'b1;
					idx_next  = idx_step;
				end
				default:
					oe_n_next = 1'b1;
			endcase
		end
		else if (scl_fall & (cnt_reg == dmcp_pkg::BITS_END))
		begin
			cnt_next  = 4'h0;
			oe_n_next = 1'b1;
			case (state_reg)
				dmcp_pkg::DS_ADDR:
				begin
					state_next = rw_reg ? dmcp_pkg::DS_RDATA : dmcp_pkg::DS_PTR;
					if (rw_reg)
					begin
						// pointer as left by the last write or read, or its reset value
						oe_n_next  = reg_rd_data[7];
						shift_next = {reg_rd_data[6:0], 1'b0};
					end
				end
				dmcp_pkg::DS_PTR:
					state_next = dmcp_pkg::DS_WDATA;
				dmcp_pkg::DS_RDATA:
				begin
					state_next = nack_reg ? dmcp_pkg::DS_SKIP : dmcp_pkg::DS_RDATA;
					oe_n_next  = nack_reg | reg_rd_data[7];
					shift_next = {reg_rd_data[6:0], 1'b0};
				end
				default:
					state_next = state_reg;
			endcase
		end
		else if (scl_fall & (state_reg == dmcp_pkg::DS_RDATA) & (cnt_reg != 4'h0))
		begin
			oe_n_next  = shift_reg[7];
			shift_next = {shift_reg[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			scl_d_reg   <= 1'b1;
			sda_d_reg   <= 1'b1;
			adcs_d_reg  <= 1'b1;
			arm_reg     <= 2'h0;
			state_reg   <= dmcp_pkg::DS_IDLE;
			cnt_reg     <= 4'h0;
			shift_reg   <= 8'h00;
			rw_reg      <= 1'b0;
			nack_reg    <= 1'b0;
			oe_n_reg    <= 1'b1;
			spi_reg     <= 1'b0;
			inc_reg     <= dmcp_pkg::PTR_INC_RST;
			idx_reg     <= dmcp_pkg::PTR_IDX_RST;
			wr_reg      <= 1'b0;
			wr_idx_reg  <= dmcp_pkg::PTR_IDX_RST;
			wr_data_reg <= 8'h00;
		end
		else
		begin
			scl_d_reg   <= scl_s;
			sda_d_reg   <= sda_s;
			adcs_d_reg  <= adcs_s;
			arm_reg     <= arm_next;
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			shift_reg   <= shift_next;
			rw_reg      <= rw_next;
			nack_reg    <= nack_next;
			oe_n_reg    <= oe_n_next;
			spi_reg     <= spi_next;
			inc_reg     <= inc_next;
			idx_reg     <= idx_next;
			wr_reg      <= wr_next;
			wr_idx_reg  <= wr_idx_next;
			wr_data_reg <= wr_data_next;
		end
	end

	assign link.dev_sda_oe_n      = oe_n_reg;
	assign reg_wr                 = wr_reg;
	assign reg_wr_index           = wr_idx_reg;
	assign reg_wr_data            = wr_data_reg;
	assign reg_rd_index           = idx_reg;
	assign spi_mode               = spi_reg;
	assign pointer_auto_increment = inc_reg;
endmodule : dmcp_device

// File: dmcp_host.sv
/*
 * dmcp_host: host end. Runs one control-port transfer per command, single
 * data byte, and makes the serial clock from clk by a quarter-bit divider.
 * assumes: software keeps the select level static in I2C use; no clock
 * stretching by the device.
 */
`timescale 1ns/1ps
module dmcp_host
#(
	parameter int QTR = dmcp_pkg::QTR_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	dmcp_if.host            link,
	input  wire logic [2:0] cmd_addr,
	input  wire logic [7:0] cmd_wdata,
	input  wire logic       cmd_wr,
	input  wire logic       cmd_rd,
	output logic      [7:0] cmd_rdata
);
	dmcp_pkg::dmcp_host_state_t st_reg;
	dmcp_pkg::dmcp_host_state_t st_next;
	logic        sda_s;
	logic [15:0] div_reg;
	logic [1:0]  q_reg;
	logic [3:0]  bit_reg;
	logic [1:0]  byte_reg;
	logic [1:0]  op_reg;
	logic [7:0]  ptr_reg;
	logic [7:0]  tx_reg;
	logic [7:0]  rx_reg;
	logic        sel_reg;
	logic        nack_reg;
	logic        scl_reg;
	logic        o_reg;
	logic        oe_n_reg;
	logic        cs_reg;
	logic [7:0]  rdata_reg;

	dmcp_sync #(.WIDTH(1), .RESET_VAL(1'h1)) u_sync
	(
		.clk   (clk),
		.rst_n (rst_n),
		.d     (link.sda),
		.q     (sda_s)
	);

	wire busy    = (st_reg != dmcp_pkg::HS_IDLE);
	wire tick    = busy & (div_reg == 16'(QTR - 1));
	wire spi     = (op_reg == dmcp_pkg::OP_SPI);
	wire reading = (op_reg == dmcp_pkg::OP_READ) & (byte_reg == 2'h1);
	wire [1:0] last_byte = ((op_reg == dmcp_pkg::OP_WRITE) | spi) ? 2'h2 : 2'h1;
	wire [3:0] last_bit  = spi ? dmcp_pkg::BITS_SPI : dmcp_pkg::BITS_ACK;
	wire [7:0] addr_byte = spi ? dmcp_pkg::SPI_ADDR
		: {dmcp_pkg::DEV_ADDR_HI, sel_reg, op_reg == dmcp_pkg::OP_READ};
	wire [7:0] cur_byte = (byte_reg == 2'h0) ? addr_byte : (byte_reg == 2'h1) ? ptr_reg : tx_reg;
	wire data_bit  = cur_byte[3'(4'h7 - bit_reg)];
	wire drive_bit = (bit_reg < dmcp_pkg::BITS_ACK) & ~reading;
	wire go        = cmd_wr & ~busy & (cmd_addr == dmcp_pkg::HR_CMD);
	wire byte_done = (q_reg == dmcp_pkg::Q_FALL) & (bit_reg == last_bit);
	wire end_frame = byte_done & ((byte_reg == last_byte) | nack_reg);

	always_comb
	begin
		st_next = st_reg;
		case (st_reg)
			dmcp_pkg::HS_IDLE:  st_next = go ? dmcp_pkg::HS_START : dmcp_pkg::HS_IDLE;
			dmcp_pkg::HS_START: st_next = (tick & (q_reg == dmcp_pkg::Q_FALL)) ? dmcp_pkg::HS_BIT : st_reg;
			dmcp_pkg::HS_BIT:   st_next = (tick & end_frame) ? dmcp_pkg::HS_STOP : st_reg;
			default:            st_next = (tick & (q_reg == dmcp_pkg::Q_FALL)) ? dmcp_pkg::HS_IDLE : st_reg;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_reg <= dmcp_pkg::HS_IDLE;
			div_reg <= 16'h0000;
			q_reg <= 2'h0;
			bit_reg <= 4'h0;
			byte_reg <= 2'h0;
			op_reg <= dmcp_pkg::OP_WRITE;
			ptr_reg <= 8'h00;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			sel_reg <= 1'b1;
			nack_reg <= 1'b0;
			scl_reg <= 1'b1;
			o_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			cs_reg <= 1'b1;
			rdata_reg <= 8'h00;
		end
		else
		begin
			st_reg <= st_next;
			div_reg <= (tick | ~busy) ? 16'h0000 : div_reg + 16'h0001;
			rdata_reg <= (cmd_rd & (cmd_addr == dmcp_pkg::HR_RX)) ? rx_reg
				: (cmd_rd & (cmd_addr == dmcp_pkg::HR_STAT)) ? {6'h00, nack_reg, busy} : 8'h00;
			if (cmd_wr & ~busy)
			begin
				if (cmd_addr == dmcp_pkg::HR_PTR) ptr_reg <= cmd_wdata;
				if (cmd_addr == dmcp_pkg::HR_TX) tx_reg <= cmd_wdata;
				if (cmd_addr == dmcp_pkg::HR_CFG)
				begin
					sel_reg <= cmd_wdata[0];
					cs_reg  <= cmd_wdata[0];
				end
			end
			if (go)
			begin
				op_reg <= cmd_wdata[1:0];
				q_reg <= 2'h0;
				bit_reg <= 4'h0;
				byte_reg <= 2'h0;
				nack_reg <= 1'b0;
			end
			else if (tick)
			begin
				q_reg <= q_reg + 2'h1;
				if (st_reg == dmcp_pkg::HS_START)
				begin
					if (q_reg == dmcp_pkg::Q_RISE & spi) cs_reg <= 1'b0;
					if (q_reg == dmcp_pkg::Q_RISE & ~spi)
					begin
						// start needs a low data value, not only the enable
						oe_n_reg <= 1'b0;
						o_reg    <= 1'b0;
					end
					if (q_reg == dmcp_pkg::Q_FALL) scl_reg <= 1'b0;
				end
				else if (st_reg == dmcp_pkg::HS_BIT)
				begin
					if (q_reg == dmcp_pkg::Q_SET)
					begin
						// SPI drives both levels, I2C only pulls low
						o_reg    <= spi ? data_bit : 1'b0;
						oe_n_reg <= spi ? 1'b0 : ~(drive_bit & ~data_bit);
					end
					if (q_reg == dmcp_pkg::Q_RISE) scl_reg <= 1'b1;
					if (q_reg == dmcp_pkg::Q_SAMPLE & reading & (bit_reg < dmcp_pkg::BITS_ACK))
						rx_reg <= {rx_reg[6:0], sda_s};
					if (q_reg == dmcp_pkg::Q_SAMPLE & ~spi & ~reading & (bit_reg == dmcp_pkg::BITS_ACK))
						nack_reg <= sda_s;
					if (q_reg == dmcp_pkg::Q_FALL)
					begin
						scl_reg  <= 1'b0;
						bit_reg  <= byte_done ? 4'h0 : bit_reg + 4'h1;
						byte_reg <= byte_done ? byte_reg + 2'h1 : byte_reg;
					end
				end
				else if (st_reg == dmcp_pkg::HS_STOP)
				begin
					if (q_reg == dmcp_pkg::Q_SET & ~spi) oe_n_reg <= 1'b0;
					if (q_reg == dmcp_pkg::Q_RISE & spi) cs_reg <= 1'b1;
					// spi clock returns high with the select rise, never after it
					if (q_reg == dmcp_pkg::Q_RISE) scl_reg <= 1'b1;
					if (q_reg == dmcp_pkg::Q_SAMPLE)
					begin
						scl_reg  <= 1'b1;
						oe_n_reg <= 1'b1;
						o_reg    <= 1'b1;
					end
				end
			end
		end
	end

	assign link.serial_control_clock = scl_reg;
	assign link.address_select_pin   = cs_reg;
	assign link.host_sda_o           = o_reg;
	assign link.host_sda_oe_n        = oe_n_reg;
	assign cmd_rdata                 = rdata_reg;
endmodule : dmcp_host

// File: dmcp_props.sv
/*
 * dmcp_props: wire checks between the host and device ends of the control port.
 * assumes: placed beside dmcp_if; host QTR of at least 4, so scl phases >= 8 clk.
 */
`timescale 1ns/1ps
module dmcp_props
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic serial_control_clock,
	input wire logic address_select_pin,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n,
	input wire logic sda
);
	logic       spi_reg;
	logic [3:0] low_reg;
	logic [7:0] rise_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// saturating counts: clk since scl fell, scl rises since start
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			spi_reg  <= 1'b0;
			low_reg  <= 4'h0;
			rise_reg <= 8'h00;
		end
		else
		begin
			spi_reg  <= spi_reg | ~address_select_pin;
			low_reg  <= serial_control_clock ? 4'h0 : low_reg + {3'h0, low_reg != 4'hF};
			rise_reg <= ($fell(sda) && serial_control_clock) ? 8'h00 :
				rise_reg + {7'h00, $rose(serial_control_clock) && rise_reg != 8'hFF};
		end
	end

	rst_idle_a: assert property ($rose(rst_n) |-> dev_sda_oe_n && host_sda_oe_n && serial_control_clock)
		else $error("link not idle after reset");
	spi_quiet_a: assert property (spi_reg |-> dev_sda_oe_n)
		else $error("device drives data in spi mode");
	ack_delay_a: assert property ($changed(dev_sda_oe_n) |-> low_reg inside {[4'h2:4'h6]})
		else $error("device data change outside scl low window");
	ack_slot_a: assert property ($fell(dev_sda_oe_n) |-> rise_reg >= 8'h08)
		else $error("device drives before address byte ends");
	drive_bound_a: assert property ($fell(dev_sda_oe_n) |-> ##[1:400] dev_sda_oe_n)
		else $error("device holds data line too long");
	start_host_a: assert property (!spi_reg && $fell(sda) && serial_control_clock |-> !host_sda_oe_n && !host_sda_o)
		else $error("start condition not made by host");
	scl_phase_a: assert property ($rose(serial_control_clock) |=> serial_control_clock[*5])
		else $error("serial clock high phase too short");
	cs_quiet_a: assert property ((spi_reg && address_select_pin)[*3] |-> $stable(serial_control_clock))
		else $error("serial clock moves outside spi frame");

	cover property ($fell(dev_sda_oe_n) && rise_reg == 8'h08);
	cover property ($fell(dev_sda_oe_n) && rise_reg > 8'h09);
	cover property (spi_reg && $fell(address_select_pin));
endmodule : dmcp_props

// File: test_dual_mode_control_port.sv
/*
 * test_dual_mode_control_port: host and device ends joined by one dmcp_if,
 * driven through the host command port; the register file lives here.
 * assumes: QTR of 8, so a transfer takes about a thousand clk.
 */
`timescale 1ns/1ps
module test_dual_mode_control_port;
	localparam int QTR = 8;
	logic                       clk;
	logic                       rst_n;
	logic [2:0]                 cmd_addr;
	logic [7:0]                 cmd_wdata;
	logic                       cmd_wr;
	logic                       cmd_rd;
	logic [7:0]                 cmd_rdata;
	logic                       reg_wr;
	logic [dmcp_pkg::IDX_W-1:0] reg_wr_index;
	logic [7:0]                 reg_wr_data;
	logic [dmcp_pkg::IDX_W-1:0] reg_rd_index;
	logic                       spi_mode;
	logic                       pointer_auto_increment;
	logic [7:0]                 regs [16];
	logic [7:0]                 rd;
	int                         wr_count;
	int                         miscompares;
	int                         n_checks;
	wire logic [7:0]            reg_rd_data = regs[reg_rd_index];

	dmcp_if u_dmcp_if ();
	dmcp_device u_dmcp_device (.clk(clk), .rst_n(rst_n), .link(u_dmcp_if.device), .reg_wr(reg_wr),
		.reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data), .reg_rd_index(reg_rd_index),
		.reg_rd_data(reg_rd_data), .spi_mode(spi_mode), .pointer_auto_increment(pointer_auto_increment));
	dmcp_host #(.QTR(QTR)) u_dmcp_host (.clk(clk), .rst_n(rst_n), .link(u_dmcp_if.host),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
	dmcp_props u_dmcp_props (.clk(clk), .rst_n(rst_n), .serial_control_clock(u_dmcp_if.serial_control_clock),
		.address_select_pin(u_dmcp_if.address_select_pin), .host_sda_o(u_dmcp_if.host_sda_o),
		.host_sda_oe_n(u_dmcp_if.host_sda_oe_n), .dev_sda_oe_n(u_dmcp_if.dev_sda_oe_n), .sda(u_dmcp_if.sda));

	// register file outside the device
	always @(posedge clk)
	begin
		if (reg_wr)
		begin
			regs[reg_wr_index] <= reg_wr_data;
			wr_count <= wr_count + 1;
		end
	end

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// idle cycle after each strobe keeps one assignment per time step
	task automatic hw(input logic [2:0] a, input logic [7:0] d);
		cmd_addr  <= a;
		cmd_wdata <= d;
		cmd_wr    <= 1'b1;
		@(posedge clk);
		cmd_wr    <= 1'b0;
		@(posedge clk);
	endtask : hw

	task automatic hr(input logic [2:0] a, output logic [7:0] d);
		cmd_addr <= a;
		cmd_rd   <= 1'b1;
		@(posedge clk);
		cmd_rd   <= 1'b0;
		// read data stand only in this cycle; take them mid-cycle
		@(negedge clk);
		d = cmd_rdata;
		@(posedge clk);
	endtask : hr

	task automatic run_op(input logic [1:0] op, input logic [7:0] ptr, input logic [7:0] data, input bit i2c);
		int n;
		n = 0;
		hw(dmcp_pkg::HR_PTR, ptr);
		hw(dmcp_pkg::HR_TX, data);
		hw(dmcp_pkg::HR_CMD, {6'h00, op});
		do
		begin
			hr(dmcp_pkg::HR_STAT, rd);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 4000);
		check({7'h00, rd[0]}, 8'h00, "busy stuck");
		if (i2c)
			check({7'h00, rd[1]}, 8'h00, "no acknowledge");
	endtask : run_op

	task automatic expect_ptr(input logic [3:0] idx, input logic inc, input int writes);
		check({4'h0, reg_rd_index}, {4'h0, idx}, "pointer index");
		check({7'h00, pointer_auto_increment}, {7'h00, inc}, "increment flag");
		check(8'(wr_count), 8'(writes), "write count");
	endtask : expect_ptr

	task automatic read_back(input logic [7:0] exp);
		run_op(dmcp_pkg::OP_READ, 8'h00, 8'h00, 1'b1);
		hr(dmcp_pkg::HR_RX, rd);
		check(rd, exp, "read data");
	endtask : read_back

	task automatic t_reset_read();
		check({7'h00, spi_mode}, 8'h00, "mode after reset");
		expect_ptr(4'h0, 1'b0, 0);
		read_back(8'h40);
		expect_ptr(4'h0, 1'b0, 0);
	endtask : t_reset_read

	task automatic t_write_fixed();
		run_op(dmcp_pkg::OP_WRITE, 8'h03, 8'hA5, 1'b1);
		check(regs[3], 8'hA5, "written register");
		expect_ptr(4'h3, 1'b0, 1);
		read_back(8'hA5);
		expect_ptr(4'h3, 1'b0, 1);
	endtask : t_write_fixed

	// index 15 then wraps to 0 at the 4-bit boundary
	task automatic t_write_pointer_auto_increment();
		run_op(dmcp_pkg::OP_WRITE, 8'h8F, 8'h3C, 1'b1);
		check(regs[15], 8'h3C, "written register");
		expect_ptr(4'h0, 1'b1, 2);
		read_back(8'h40);
		expect_ptr(4'h1, 1'b1, 2);
	endtask : t_write_pointer_auto_increment

	task automatic t_set_ptr();
		run_op(dmcp_pkg::OP_SETPTR, 8'h76, 8'h00, 1'b1);
		expect_ptr(4'h6, 1'b0, 2);
		read_back(8'h46);
		expect_ptr(4'h6, 1'b0, 2);
	endtask : t_set_ptr

	// empty frame from the mode switch must write nothing
	task automatic t_spi();
		hw(dmcp_pkg::HR_CFG, 8'h00);
		hw(dmcp_pkg::HR_CFG, 8'h01);
		repeat (10) @(posedge clk);
		check({7'h00, spi_mode}, 8'h01, "spi mode");
		expect_ptr(4'h6, 1'b0, 2);
		run_op(dmcp_pkg::OP_SPI, 8'h89, 8'hC3, 1'b0);
		check(regs[9], 8'hC3, "spi register");
		expect_ptr(4'hA, 1'b1, 3);
		run_op(dmcp_pkg::OP_SPI, 8'h02, 8'h11, 1'b0);
		check(regs[2], 8'h11, "spi register");
		expect_ptr(4'h2, 1'b0, 4);
		check({7'h00, spi_mode}, 8'h01, "spi mode kept");
	endtask : t_spi

	initial
	begin
		rst_n       = 1'b0;
		cmd_addr    = 3'h0;
		cmd_wdata   = 8'h00;
		cmd_wr      = 1'b0;
		cmd_rd      = 1'b0;
		wr_count    = 0;
		miscompares = 0;
		n_checks    = 0;
		for (int i = 0; i < 16; i++)
			regs[i] = 8'h40 + 8'(i);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (12) @(posedge clk);
		t_reset_read();
		t_write_fixed();
		t_write_pointer_auto_increment();
		t_set_ptr();
		t_spi();
		end_of_test();
	end

	// whole run needs about 7000 clk
	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		end_of_test();
	end
endmodule : test_dual_mode_control_port
